// [inc/link_pkg.sv]
// Constants shared by the antenna polling link controller and its CRC unit.
package link_pkg;

    localparam int CLK_HZ         = 50_000_000;
    localparam int STREAM_BPS     = 250_000;
    localparam int MAIN_BPS       = 125_000;
    localparam int VOICE_BPS      = 62_250;
    localparam int AUX_BPS        = 15_625;
    localparam int STREAM_BIT_CYC = CLK_HZ / STREAM_BPS;
    localparam int MBUS_BPS       = 9_600;
    localparam int SERVO_BPS      = 9_600;
    localparam int MBUS_CYCLE_MS  = 1000;
    localparam int MBUS_MODULES   = 16;

    localparam int ANT_TOTAL  = 30;
    localparam int ANT_FIRST  = 20;
    localparam int ANT_SECOND = 10;
    localparam int MAX_TRIES  = 3;

    // Main frame: flag, address, payload, CRC, flag; bit counts.
    localparam int FRAME_BITS = 56;
    localparam int ADDR_START = 8;
    localparam int CRC_POS    = 32;
    localparam int RX_BITS    = 40;
    localparam int MB_CHAR_BITS = 11;
    localparam int SV_CHAR_BITS = 10;

    localparam logic [7:0]  FLAG          = 8'h7E;
    localparam logic [4:0]  BCAST_ADDR    = 5'h1F;
    localparam logic [4:0]  LOCAL_ADDR    = 5'h1E;
    localparam logic [15:0] POLL_CMD      = 16'h0001;
    localparam logic [15:0] CRC16_POLY    = 16'h1021;
    localparam logic [7:0]  CRC8_POLY     = 8'h07;
    localparam logic [3:0]  FEED_POS_ADDR = 4'hF;
    localparam logic [7:0]  MB_POLL_CODE  = 8'h01;
    localparam logic [7:0]  SERVO_PARK_OP = 8'h50;
    localparam logic [7:0]  PARK_EL_DEG   = 8'h5A;
    localparam logic [7:0]  PARK_AZ_DEG   = 8'h00;

endpackage : link_pkg

// [inc/crc_if.sv]
// Interface between a serial CRC unit and the logic that feeds it.
`timescale 1ns/1ps
interface crc_if #(parameter int W = 16)
(
    input wire logic clock,
    input wire logic rst
);
    logic         clr;
    logic         en;
    logic         din;
    logic [W-1:0] crc;

    modport user   (output clr, output en, output din, input crc);
    modport engine (input clock, input rst, input clr, input en,
                    input din, output crc);
endinterface : crc_if

// [hw/crc_serial.sv]
// Bit-serial CRC register, MSB first, zero initial value.
`timescale 1ns/1ps
module crc_serial #(
    parameter int           W    = 16,
    parameter logic [W-1:0] POLY = '0
)
(
    crc_if.engine bus
);

    typedef struct packed {
        logic [W-1:0] crc;
    } crc_state_t;

    crc_state_t q;
    crc_state_t d;
    logic       fb;

    always_comb
    begin
        d  = q;
        fb = q.crc[W-1] ^ bus.din;
        if (bus.clr)
        begin
            d.crc = '0;
        end
        else if (bus.en)
        begin
            d.crc = {q.crc[W-2:0], 1'b0} ^ (fb ? POLY : '0);
        end
    end

    always_ff @(posedge bus.clock or posedge bus.rst)
    begin
        if (bus.rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign bus.crc = q.crc;

endmodule : crc_serial

// [hw/antenna_comm_handler.sv]
// Antenna polling link controller with module bus and servo park links.
//
// Overview of operation
// - Reset leaves the handler in polling mode.
// - Send selected antenna's frame, then await reply.
// - Good reply in time selects the next antenna.
// - Timeout or bad check resends to same antenna.
// - Third failure reports error type, then moves on.
// - Thirty antennas exist across both handlers.
// - First handler serves twenty, second serves ten.
// - Common command goes out once as broadcast.
// - Broadcast frames wait for no acknowledgement.
// - Main link carries framed data at 125 Kbps.
// - Channels bit-interleave into one 250 Kbps stream.
// - Four auxiliary channels of 15.625 Kbps each.
// - One voice channel in the combined stream.
// - Main frames carry 16-bit CRC, errors retried.
// - Local commands are forwarded to addressed module.
// - Poll sixteen modules within one second.
// - Each module's monitoring can be enabled or disabled.
// - Feed positioner answers at module address 15.
// - Module bus uses 9-bit characters at 9.6 Kbps.
// - Module bus frames carry an 8-bit CRC.
// - Servo link is asynchronous serial at 9.6 Kbps.
// - Park request drives antenna to El 90, Az 0.
`timescale 1ns/1ps
module antenna_comm_handler
    import link_pkg::*;
#(
    parameter bit SECOND        = 1'b0,
    parameter int MBUS_BIT_CYC  = link_pkg::CLK_HZ / link_pkg::MBUS_BPS,
    parameter int MBUS_SLOT_CYC = link_pkg::CLK_HZ / 1000
                                  * link_pkg::MBUS_CYCLE_MS
                                  / link_pkg::MBUS_MODULES
)
(
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rst,
    // Supervisor command port.
    input  wire logic        cmd_valid,
    input  wire logic        cmd_broadcast,
    input  wire logic [4:0]  cmd_antenna,
    input  wire logic [15:0] cmd_word,
    output logic             cmd_ready,
    input  wire logic [23:0] timeout_cycles,
    // Supervisor report port.
    output logic             reply_valid,
    output logic [4:0]       reply_antenna,
    output logic [15:0]      reply_data,
    output logic             err_valid,
    output logic [4:0]       err_antenna,
    output logic             err_timeout,
    output logic             broadcast_mode,
    // Combined 250 Kbps link.
    output logic             link_tx,
    input  wire logic        link_rx,
    input  wire logic        voice_tx,
    output logic             voice_rx,
    input  wire logic [3:0]  aux_tx,
    output logic [3:0]       aux_rx,
    // Module bus.
    input  wire logic [15:0] mbus_enable,
    output logic             mbus_out,
    output logic             mbus_oe,
    output logic             feed_sel,
    // Servo link.
    input  wire logic        park_req,
    output logic             servo_tx
);
    import link_pkg::*;

    localparam int N_ANT = SECOND ? ANT_SECOND : ANT_FIRST;
    localparam int BASE  = SECOND ? ANT_FIRST : 0;

    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} poll_state_t;

    typedef struct packed {
        poll_state_t  st;
        logic         bcast;
        logic [4:0]   ant;
        logic [1:0]   tries;
        logic [23:0]  tmo;
        logic [7:0]   div;
        logic [3:0]   slot;
        logic [7:0]   tx_addr;
        logic [15:0]  tx_pay;
        logic [55:0]  tx_sh;
        logic [5:0]   tx_cnt;
        logic [1:0]   rx_meta;
        logic [7:0]   rx_hunt;
        logic         rx_on;
        logic [5:0]   rx_cnt;
        logic [39:0]  rx_buf;
        logic         rx_chk;
        logic         link_tx;
        logic         voice_rx;
        logic [3:0]   aux_rx;
        logic         cmd_ready;
        logic         rep_valid;
        logic [4:0]   rep_ant;
        logic [15:0]  rep_data;
        logic         err_valid;
        logic [4:0]   err_ant;
        logic         err_tmo;
        logic [12:0]  baud;
        logic [21:0]  mb_tmr;
        logic [3:0]   mb_addr;
        logic [10:0]  mb_sh;
        logic [3:0]   mb_bit;
        logic [1:0]   mb_chr;
        logic         mb_busy;
        logic [7:0]   mb_data;
        logic         mb_tx;
        logic         mb_oe;
        logic         feed_sel;
        logic [9:0]   sv_sh;
        logic [3:0]   sv_bit;
        logic [1:0]   sv_chr;
        logic         sv_busy;
        logic         park_q;
        logic         sv_tx;
    } state_t;

    state_t q;
    state_t d;

    crc_if #(.W(16)) tx_crc (.clock(clock), .rst(rst));
    crc_if #(.W(16)) rx_crc (.clock(clock), .rst(rst));
    crc_if #(.W(8))  mb_crc (.clock(clock), .rst(rst));

    crc_serial #(.W(16), .POLY(CRC16_POLY)) u_tx_crc (.bus(tx_crc.engine));
    crc_serial #(.W(16), .POLY(CRC16_POLY)) u_rx_crc (.bus(rx_crc.engine));
    crc_serial #(.W(8),  .POLY(CRC8_POLY))  u_mb_crc (.bus(mb_crc.engine));

    logic        strobe;
    logic        baud_tick;
    logic        main_slot;
    logic        rx_bit;
    logic [55:0] tx_cur;
    logic [4:0]  gaddr;
    logic        go;
    logic        failed;
    logic        fail_tmo;
    logic        advance;
    logic        mb_start;
    logic [3:0]  mb_start_addr;
    logic [7:0]  mb_start_data;
    logic        fwd_go;

    always_comb
    begin
        d             = q;
        strobe        = (q.div == 8'(STREAM_BIT_CYC - 1));
        baud_tick     = (q.baud == 13'(MBUS_BIT_CYC - 1));
        main_slot     = ~q.slot[0];
        rx_bit        = q.rx_meta[1];
        gaddr         = 5'(BASE) + q.ant;
        go            = 1'b0;
        failed        = 1'b0;
        fail_tmo      = 1'b0;
        advance       = 1'b0;
        mb_start      = 1'b0;
        mb_start_addr = q.mb_addr;
        mb_start_data = MB_POLL_CODE;
        // The CRC is spliced into the frame as it reaches the line.
        tx_cur = (q.tx_cnt == 6'(CRC_POS)) ? {tx_crc.crc, q.tx_sh[39:0]}
                                           : q.tx_sh;
        tx_crc.clr = 1'b0;
        tx_crc.en  = 1'b0;
        tx_crc.din = tx_cur[55];
        rx_crc.clr = 1'b0;
        rx_crc.en  = 1'b0;
        rx_crc.din = rx_bit;
        mb_crc.clr = 1'b0;
        mb_crc.en  = 1'b0;
        mb_crc.din = q.mb_sh[0];
        fwd_go = (q.st == ST_IDLE) && (q.tries == 2'h0) && cmd_valid
                 && !cmd_broadcast && (cmd_antenna == LOCAL_ADDR)
                 && !q.mb_busy;

        d.rx_meta   = {q.rx_meta[0], link_rx};
        d.cmd_ready = 1'b0;
        d.rep_valid = 1'b0;
        d.err_valid = 1'b0;
        d.rx_chk    = 1'b0;
        d.div       = strobe ? 8'h00 : q.div + 8'h01;

        // Sixteen-slot interleave: even slots main, 1/5/9/13 voice,
        // 3/7/11/15 one auxiliary channel each.
        if (strobe)
        begin
            d.slot = q.slot + 4'h1;
            if (main_slot)
            begin
                d.link_tx = (q.st == ST_SEND) ? tx_cur[55] : 1'b1;
                if (q.st == ST_SEND)
                begin
                    d.tx_sh   = {tx_cur[54:0], 1'b1};
                    d.tx_cnt  = q.tx_cnt + 6'h01;
                    tx_crc.en = (q.tx_cnt >= 6'(ADDR_START))
                                && (q.tx_cnt < 6'(CRC_POS));
                end
                if (!q.rx_on)
                begin
                    d.rx_hunt = {q.rx_hunt[6:0], rx_bit};
                    if ({q.rx_hunt[6:0], rx_bit} == FLAG)
                    begin
                        d.rx_on    = 1'b1;
                        d.rx_cnt   = 6'h00;
                        rx_crc.clr = 1'b1;
                    end
                end
                else
                begin
                    d.rx_buf  = {q.rx_buf[38:0], rx_bit};
                    rx_crc.en = 1'b1;
                    d.rx_cnt  = q.rx_cnt + 6'h01;
                    if (q.rx_cnt == 6'(RX_BITS - 1))
                    begin
                        d.rx_on   = 1'b0;
                        d.rx_hunt = 8'h00;
                        d.rx_chk  = 1'b1;
                    end
                end
            end
            else if (!q.slot[1])
            begin
                d.link_tx  = voice_tx;
                d.voice_rx = rx_bit;
            end
            else
            begin
                d.link_tx              = aux_tx[q.slot[3:2]];
                d.aux_rx[q.slot[3:2]]  = rx_bit;
            end
        end

        case (q.st)
            ST_IDLE:
            begin
                if (q.tries != 2'h0)
                begin
                    go = 1'b1;
                end
                else if (cmd_valid && cmd_broadcast)
                begin
                    d.bcast     = 1'b1;
                    d.tx_addr   = {3'b000, BCAST_ADDR};
                    d.tx_pay    = cmd_word;
                    d.cmd_ready = 1'b1;
                    go          = 1'b1;
                end
                else if (cmd_valid && (cmd_antenna == LOCAL_ADDR))
                begin
                    d.cmd_ready = fwd_go;
                end
                else
                begin
                    d.bcast   = 1'b0;
                    d.tx_addr = {3'b000, gaddr};
                    d.tx_pay  = POLL_CMD;
                    if (cmd_valid && (cmd_antenna == gaddr))
                    begin
                        d.tx_pay    = cmd_word;
                        d.cmd_ready = 1'b1;
                    end
                    go = 1'b1;
                end
                if (go)
                begin
                    d.st       = ST_SEND;
                    d.tx_cnt   = 6'h00;
                    d.tx_sh    = {FLAG, d.tx_addr, d.tx_pay, 16'h0000, FLAG};
                    tx_crc.clr = 1'b1;
                end
            end
            ST_SEND:
            begin
                if (strobe && main_slot
                    && (q.tx_cnt == 6'(FRAME_BITS - 1)))
                begin
                    if (q.bcast)
                    begin
                        d.st    = ST_IDLE;
                        d.bcast = 1'b0;
                    end
                    else
                    begin
                        d.st  = ST_WAIT;
                        d.tmo = 24'h000000;
                    end
                end
            end
            ST_WAIT:
            begin
                d.tmo = q.tmo + 24'h000001;
                if (q.rx_chk && (q.rx_buf[39:32] == q.tx_addr))
                begin
                    if (rx_crc.crc == 16'h0000)
                    begin
                        d.rep_valid = 1'b1;
                        d.rep_ant   = gaddr;
                        d.rep_data  = q.rx_buf[31:16];
                        d.tries     = 2'h0;
                        d.st        = ST_IDLE;
                        advance     = 1'b1;
                    end
                    else
                    begin
                        failed = 1'b1;
                    end
                end
                else if (q.tmo >= timeout_cycles)
                begin
                    failed   = 1'b1;
                    fail_tmo = 1'b1;
                end
            end
            default:
            begin
                d.st = ST_IDLE;
            end
        endcase

        if (failed)
        begin
            d.st = ST_IDLE;
            if (q.tries == 2'(MAX_TRIES - 1))
            begin
                d.err_valid = 1'b1;
                d.err_ant   = gaddr;
                d.err_tmo   = fail_tmo;
                d.tries     = 2'h0;
                advance     = 1'b1;
            end
            else
            begin
                d.tries = q.tries + 2'h1;
            end
        end
        if (advance)
        begin
            d.ant = (q.ant == 5'(N_ANT - 1)) ? 5'h00 : q.ant + 5'h01;
        end

        // Module bus: one slot per address, sixteen slots per cycle.
        d.baud   = baud_tick ? 13'h0000 : q.baud + 13'h0001;
        d.mb_tmr = q.mb_tmr + 22'h000001;
        if (q.mb_tmr == 22'(MBUS_SLOT_CYC - 1))
        begin
            d.mb_tmr  = 22'h000000;
            d.mb_addr = q.mb_addr + 4'h1;
            mb_start  = mbus_enable[q.mb_addr] && !q.mb_busy && !fwd_go;
        end
        if (fwd_go)
        begin
            mb_start      = 1'b1;
            mb_start_addr = cmd_word[11:8];
            mb_start_data = cmd_word[7:0];
        end
        if (mb_start)
        begin
            d.mb_busy  = 1'b1;
            d.mb_oe    = 1'b1;
            d.mb_chr   = 2'h0;
            d.mb_bit   = 4'h0;
            d.mb_sh    = {2'b11, 4'h0, mb_start_addr, 1'b0};
            d.mb_data  = mb_start_data;
            d.feed_sel = (mb_start_addr == FEED_POS_ADDR);
            mb_crc.clr = 1'b1;
        end
        else if (q.mb_busy && baud_tick)
        begin
            if (q.mb_chr == 2'h3)
            begin
                d.mb_busy  = 1'b0;
                d.mb_oe    = 1'b0;
                d.mb_tx    = 1'b1;
                d.feed_sel = 1'b0;
            end
            else
            begin
                d.mb_tx   = q.mb_sh[0];
                d.mb_sh   = {1'b1, q.mb_sh[10:1]};
                d.mb_bit  = q.mb_bit + 4'h1;
                mb_crc.en = (q.mb_chr != 2'h2) && (q.mb_bit >= 4'h1)
                            && (q.mb_bit <= 4'h8);
                if (q.mb_bit == 4'(MB_CHAR_BITS - 1))
                begin
                    d.mb_bit = 4'h0;
                    d.mb_chr = q.mb_chr + 2'h1;
                    if (q.mb_chr == 2'h0)
                    begin
                        d.mb_sh = {2'b10, q.mb_data, 1'b0};
                    end
                    else if (q.mb_chr == 2'h1)
                    begin
                        d.mb_sh = {2'b10, mb_crc.crc, 1'b0};
                    end
                end
            end
        end

        // Servo link: a park request sends opcode, elevation, azimuth.
        d.park_q = park_req;
        if (park_req && !q.park_q && !q.sv_busy)
        begin
            d.sv_busy = 1'b1;
            d.sv_chr  = 2'h0;
            d.sv_bit  = 4'h0;
            d.sv_sh   = {1'b1, SERVO_PARK_OP, 1'b0};
        end
        else if (q.sv_busy && baud_tick)
        begin
            d.sv_tx  = q.sv_sh[0];
            d.sv_sh  = {1'b1, q.sv_sh[9:1]};
            d.sv_bit = q.sv_bit + 4'h1;
            if (q.sv_bit == 4'(SV_CHAR_BITS - 1))
            begin
                d.sv_bit = 4'h0;
                d.sv_chr = q.sv_chr + 2'h1;
                if (q.sv_chr == 2'h0)
                begin
                    d.sv_sh = {1'b1, PARK_EL_DEG, 1'b0};
                end
                else if (q.sv_chr == 2'h1)
                begin
                    d.sv_sh = {1'b1, PARK_AZ_DEG, 1'b0};
                end
                else
                begin
                    d.sv_busy = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            q         <= '0;
            q.link_tx <= 1'b1;
            q.mb_tx   <= 1'b1;
            q.sv_tx   <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign cmd_ready      = q.cmd_ready;
    assign reply_valid    = q.rep_valid;
    assign reply_antenna  = q.rep_ant;
    assign reply_data     = q.rep_data;
    assign err_valid      = q.err_valid;
    assign err_antenna    = q.err_ant;
    assign err_timeout    = q.err_tmo;
    assign broadcast_mode = q.bcast;
    assign link_tx        = q.link_tx;
    assign voice_rx       = q.voice_rx;
    assign aux_rx         = q.aux_rx;
    assign mbus_out       = q.mb_tx;
    assign mbus_oe        = q.mb_oe;
    assign feed_sel       = q.feed_sel;
    assign servo_tx       = q.sv_tx;

endmodule : antenna_comm_handler

// [verif/link_monitor.sv]
// Port assertions for the link controller.
`timescale 1ns/1ps
module link_monitor
    import link_pkg::*;
#(
    parameter bit SECOND = 1'b0
)
(
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       cmd_valid,
    input wire logic       cmd_broadcast,
    input wire logic       cmd_ready,
    input wire logic       reply_valid,
    input wire logic [4:0] reply_antenna,
    input wire logic       err_valid,
    input wire logic [4:0] err_antenna,
    input wire logic       broadcast_mode,
    input wire logic       mbus_out,
    input wire logic       mbus_oe,
    input wire logic       park_req
);
    localparam logic [4:0] LO = SECOND ? 5'h14 : 5'h00;
    localparam logic [4:0] HI = SECOND ? 5'h1D : 5'h13;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    chk_ready_one_cycle: assert property (cmd_ready |=> !cmd_ready)
        else $error("cmd_ready held too long");
    chk_ready_after_valid: assert property (
        $rose(cmd_ready) |-> $past(cmd_valid))
        else $error("cmd_ready without a request");
    chk_bcast_mode_on: assert property (
        cmd_ready && $past(cmd_broadcast) |-> broadcast_mode)
        else $error("broadcast mode not entered");
    chk_bcast_holds: assert property (
        $rose(broadcast_mode) |-> broadcast_mode[*8])
        else $error("broadcast dropped early");
    chk_bcast_no_ack: assert property (
        broadcast_mode |-> !reply_valid && !err_valid)
        else $error("reply handled during broadcast");
    chk_reply_pulse: assert property (reply_valid |=> !reply_valid)
        else $error("reply_valid stretched");
    chk_err_pulse: assert property (err_valid |=> !err_valid)
        else $error("err_valid stretched");
    chk_reply_range: assert property (
        reply_valid |-> reply_antenna >= LO && reply_antenna <= HI)
        else $error("reply antenna out of range");
    chk_err_range: assert property (
        err_valid |-> err_antenna >= LO && err_antenna <= HI)
        else $error("err antenna out of range");
    chk_mbus_idle_high: assert property (!mbus_oe |-> mbus_out)
        else $error("module bus not idle high");
    chk_oe_holds: assert property ($rose(mbus_oe) |-> mbus_oe[*8])
        else $error("module bus frame cut short");

    cov_reply: cover property (reply_valid);
    cov_error: cover property (err_valid);
    cov_mbus_frame: cover property ($rose(mbus_oe));
    cov_park: cover property ($rose(park_req));
endmodule : link_monitor

bind antenna_comm_handler link_monitor #(.SECOND(SECOND))
    link_monitor_i (.*);

// [verif/link_far_end.sv]
// Antenna-side model of the combined link.
`timescale 1ns/1ps
module link_far_end
    import link_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       link_tx,
    input  wire logic [1:0] mode,
    output logic            link_rx,
    output logic [7:0]      last_addr,
    output int              frames
);
    logic [55:0] rx_sr;
    logic [55:0] tx_sr;
    logic [7:0]  addr;
    int          phase;
    int          tx_left;

    function automatic logic [15:0] crc16(input logic [23:0] v);
        logic [15:0] c;
        c = '0;
        for (int i = 23; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? CRC16_POLY : 16'h0000);
        return c;
    endfunction : crc16

    assign addr = rx_sr[46:39];

    // Main bits are sampled mid odd slot and changed mid even slot.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            phase <= 0; link_rx <= 1'b1; rx_sr <= '1; tx_sr <= '1;
            tx_left <= 0; frames <= 0; last_addr <= 8'h00;
        end
        else
        begin
            phase <= (phase == 399) ? 0 : phase + 1;
            if (phase == 300)
            begin
                rx_sr <= {rx_sr[54:0], link_tx};
                if (rx_sr[54:47] == FLAG && {rx_sr[6:0], link_tx} == FLAG)
                begin
                    frames <= frames + 1;
                    last_addr <= addr;
                    if (mode != 2'h0 && addr[4:0] != BCAST_ADDR)
                    begin
                        tx_sr <= {8'hFF, FLAG, addr, 8'hC3, addr,
                            crc16({addr, 8'hC3, addr})
                            ^ ((mode == 2'h2) ? 16'hFFFF : 16'h0000)};
                        tx_left <= 56;
                    end
                end
            end
            if (phase == 100)
            begin
                link_rx <= (tx_left > 0) ? tx_sr[55] : 1'b1;
                if (tx_left > 0)
                begin
                    tx_sr <= {tx_sr[54:0], 1'b1};
                    tx_left <= tx_left - 1;
                end
            end
        end
    end
endmodule : link_far_end

// [verif/antenna_poll_link_controller_tb_top.sv]
// Testbench for the antenna polling link controller.
`timescale 1ns/1ps
module antenna_poll_link_controller_tb_top;
    import link_pkg::*;
    localparam int BIT_CYC = 4;
    logic clock = 0, rst = 1, cmd_valid = 0, cmd_broadcast = 0, park_req = 0;
    logic [4:0]  cmd_antenna = 5'h00;
    logic [15:0] cmd_word = 16'h0000, mbus_enable = 16'h8000;
    logic [23:0] timeout_cycles = 24'h000000;
    logic        voice_tx = 0, cmd_ready, reply_valid, err_valid, err_timeout;
    logic [3:0]  aux_tx = 4'h0, aux_rx;
    logic [4:0]  reply_antenna, err_antenna;
    logic [15:0] reply_data;
    logic        broadcast_mode, link_tx, link_rx, voice_rx;
    logic        mbus_out, mbus_oe, feed_sel, servo_tx;
    logic [1:0]  far_mode = 2'h0;
    logic [7:0]  last_addr;
    logic [9:0]  ch;
    int          frames, num_errors = 0, num_checks = 0;

    always #10 clock = ~clock;
    always @(negedge clock) {aux_tx, voice_tx} <= {aux_tx, voice_tx} + 5'h01;

    antenna_comm_handler #(.MBUS_BIT_CYC(BIT_CYC), .MBUS_SLOT_CYC(400))
    antenna_comm_handler_i (.*);

    link_far_end link_far_end_i (.clock(clock), .rst(rst),
        .link_tx(link_tx), .mode(far_mode), .link_rx(link_rx),
        .last_addr(last_addr), .frames(frames));

    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic compare(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : compare

    task automatic stall(input string what);
        num_errors++;
        $display("wrong value %s expected event seen timeout", what);
        give_verdict();
    endtask : stall

    function automatic logic line(input bit sel);
        return sel ? mbus_out : servo_tx;
    endfunction : line

    // Samples one character mid-bit.
    task automatic get_char(input bit sel, input int nbits);
        int n;
        ch = '1;
        for (n = 0; n < 20000 && line(sel) !== 1'b0; n++) @(negedge clock);
        if (n == 20000) stall("start bit");
        repeat (2) @(negedge clock);
        for (int i = 0; i < nbits; i++)
        begin
            repeat (BIT_CYC) @(negedge clock);
            ch[i] = line(sel);
        end
    endtask : get_char

    task automatic test_reset;
        compare("broadcast_mode", 16'h0000, broadcast_mode);
        compare("link_tx idle", 16'h0001, link_tx);
        compare("mbus_oe idle", 16'h0000, mbus_oe);
        compare("servo_tx idle", 16'h0001, servo_tx);
        $display("test reset done");
    endtask : test_reset

    task automatic test_park;
        logic [7:0] exp [3];
        exp = '{SERVO_PARK_OP, PARK_EL_DEG, PARK_AZ_DEG};
        park_req = 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            get_char(1'b0, 9);
            compare("servo char", {8'h01, exp[k]}, ch[8:0]);
        end
        park_req = 1'b0;
        $display("test park done");
    endtask : test_park

    task automatic test_mbus;
        int n;
        for (n = 0; n < 8000 && mbus_oe !== 1'b1; n++) @(negedge clock);
        if (n == 8000) stall("mbus_oe");
        compare("feed_sel", 16'h0001, feed_sel);
        get_char(1'b1, 10);
        compare("mbus address char", 16'h030F, ch);
        get_char(1'b1, 10);
        compare("mbus data char", {8'h02, MB_POLL_CODE}, ch);
        $display("test mbus done");
    endtask : test_mbus

    task automatic test_retry_fail;
        int n;
        for (n = 0; n < 80000 && err_valid !== 1'b1; n++) @(negedge clock);
        if (n == 80000) stall("err_valid");
        repeat (200) @(negedge clock);
        compare("err_antenna", 16'h0000, err_antenna);
        compare("err_timeout", 16'h0001, err_timeout);
        compare("frames sent", 16'h0003, frames[15:0]);
        compare("polled address", 16'h0000, last_addr);
        timeout_cycles = 24'd30000;
        far_mode = 2'h1;
        $display("test retry done");
    endtask : test_retry_fail

    task automatic test_good_reply;
        int n;
        for (n = 0; n < 50000 && reply_valid !== 1'b1; n++)
            @(negedge clock);
        if (n == 50000) stall("reply_valid");
        compare("reply_antenna", 16'h0001, reply_antenna);
        compare("reply_data", 16'hC301, reply_data);
        compare("polled address", 16'h0001, last_addr);
        $display("test reply done");
    endtask : test_good_reply

    initial
    begin
        repeat (8) @(negedge clock);
        test_reset();
        rst = 1'b0;
        test_park();
        test_mbus();
        test_retry_fail();
        test_good_reply();
        give_verdict();
    end
endmodule : antenna_poll_link_controller_tb_top
